//--- hdl/byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rstN,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic [AW-1:0] next_wrPtr;
   logic [AW-1:0] next_rdPtr;
   logic [AW:0] next_count;
   logic [WIDTH-1:0] next_outData;
   logic next_outValid;
   logic push;
   logic pop;
   logic memEmpty;

   // ----------------------------------------------------------------
   // Pointer arithmetic
   // ----------------------------------------------------------------
   function automatic logic [AW-1:0] incPtr(input logic [AW-1:0] p);
      incPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // The output register is refilled whenever it is empty or drained.
   assign memEmpty = (count == '0);
   assign inReady = (count != (AW+1)'(DEPTH));
   assign push = inValid && inReady;
   assign pop = !memEmpty && (!outValid || outReady);

   // Next pointers, fill level and output word.
   always_comb begin
      next_wrPtr = push ? incPtr(wrPtr) : wrPtr;
      next_rdPtr = pop ? incPtr(rdPtr) : rdPtr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      next_outData = pop ? mem[rdPtr] : outData;
      next_outValid = pop ? 1'b1 : (outValid && !outReady);
   end

   // State registers; the storage array holds no reset.
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         outData <= '0;
         outValid <= 1'b0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
         outData <= next_outData;
         outValid <= next_outValid;
      end
   end

   // Storage write.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule

//--- hdl/fieldbus_slave_diag_framer.sv
`timescale 1ns/100ps
// Overview of operation
// - Sync and freeze act only when this slave belongs to an addressed group.
// - Diagnostics report protocol operating state and, when present, the cause.
// - Pending local event makes data-exchange responses high priority.
// - With no pending event, data-exchange responses are marked low priority.
// - A diagnostic request is answered whenever the builder is idle, event or not.
// - Bytes 0-2 hold station status 1-3, byte 3 the master address.
// - Bytes 4 and 5 hold the identification number, high byte first.
// - Header byte 6 is 0x42, byte 7 bit 0 flags more, bytes 8-16 fixed.
module fieldbus_slave_diag_framer
   import diag_framer_pkg::*;
#(
   parameter logic [15:0] IDENT_NUMBER = 16'h1234, // Arbitrary neutral value.
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] groupMember,
   input wire logic cmdValid,
   input wire group_cmd_t cmd,
   input wire logic [7:0] masterAddr,
   input wire logic masterAddrValid,
   input wire logic paramDone,
   input wire logic diagEvent,
   input wire logic devDiagAvail,
   input wire logic diagReq,
   output logic diagBusy,
   output logic frameValid,
   input wire logic frameReady,
   output frame_byte_t frameOut,
   input wire logic dxReq,
   output logic dxHighPrio,
   output logic syncActive,
   output logic freezeActive
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rstMeta;
   logic rstN;

   // The reset is asserted at once but released through two stages, so
   // every flop reset by rstN leaves reset on the same edge.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // ----------------------------------------------------------------
   // Group control state
   // ----------------------------------------------------------------
   logic next_syncActive;
   logic next_freezeActive;
   logic addressed;

   // A command counts only if one of its groups holds this slave.
   assign addressed = cmdValid && ((cmd.groups & groupMember) != 8'h00);

   // Decode the four group commands; other codes leave the state alone.
   always_comb begin
      next_syncActive = syncActive;
      next_freezeActive = freezeActive;
      if (addressed) begin
         case (cmd.code)
            CMD_SYNC: next_syncActive = 1'b1;
            CMD_UNSYNC: next_syncActive = 1'b0;
            CMD_FREEZE: next_freezeActive = 1'b1;
            CMD_UNFREEZE: next_freezeActive = 1'b0;
            default: begin
               next_syncActive = syncActive;
               next_freezeActive = freezeActive;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         syncActive <= 1'b0;
         freezeActive <= 1'b0;
      end else begin
         syncActive <= next_syncActive;
         freezeActive <= next_freezeActive;
      end
   end

   // ----------------------------------------------------------------
   // Master address, parameter state and pending event
   // ----------------------------------------------------------------
   logic [7:0] masterReg;
   logic [7:0] next_masterReg;
   logic paramOk;
   logic next_paramOk;
   logic eventPending;
   logic next_eventPending;
   logic frameTaken;
   logic snapTaken;
   logic eventSinceSnap;
   logic next_eventSinceSnap;

   // The master has read a frame once it takes the byte flagged last.
   assign frameTaken = frameValid && frameReady && frameOut.last;

   // The pending event clears only after the master has read the frame,
   // and not if an event came after the status snapshot: that event is
   // not in the frame, so it must keep the priority high. A new event
   // wins over the clear in the same cycle.
   always_comb begin
      next_masterReg = masterAddrValid ? masterAddr : masterReg;
      next_paramOk = paramOk || paramDone;
      next_eventPending = eventPending;
      next_eventSinceSnap = eventSinceSnap;
      if (snapTaken) begin
         next_eventSinceSnap = 1'b0;
      end
      if (frameTaken && !eventSinceSnap) begin
         next_eventPending = 1'b0;
      end
      if (diagEvent) begin
         next_eventPending = 1'b1;
         next_eventSinceSnap = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         masterReg <= MASTER_ADDR_RST;
         paramOk <= 1'b0;
         eventPending <= 1'b0;
         eventSinceSnap <= 1'b0;
      end else begin
         masterReg <= next_masterReg;
         paramOk <= next_paramOk;
         eventPending <= next_eventPending;
         eventSinceSnap <= next_eventSinceSnap;
      end
   end

   // ----------------------------------------------------------------
   // Response priority
   // ----------------------------------------------------------------
   logic next_dxHighPrio;

   // The priority is sampled once per data-exchange request and held
   // until the next one, so one response frame carries one flag.
   always_comb begin
      next_dxHighPrio = dxHighPrio;
      if (dxReq) begin
         next_dxHighPrio = eventPending;
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         dxHighPrio <= 1'b0;
      end else begin
         dxHighPrio <= next_dxHighPrio;
      end
   end

   // ----------------------------------------------------------------
   // Diagnostic frame builder
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      IDLE = 2'b01,
      SEND = 2'b10
   } build_state_t;

   build_state_t state;
   build_state_t next_state;
   logic [4:0] idx;
   logic [4:0] next_idx;
   logic [7:0] snapSt1;
   logic [7:0] next_snapSt1;
   logic [7:0] snapSt2;
   logic [7:0] next_snapSt2;
   logic snapDev;
   logic next_snapDev;
   logic [7:0] curByte;
   logic fifoInReady;
   logic pushByte;

   // Status bytes are captured when the request is taken so a frame is
   // self-consistent even if an event lands mid-frame.
   function automatic logic [7:0] stat1(input logic ev);
      stat1 = 8'h00;
      stat1[ST1_EXT_DIAG_BIT] = ev;
   endfunction

   function automatic logic [7:0] stat2(input logic pOk, input logic sy,
                                        input logic fr);
      stat2 = 8'h00;
      stat2[ST2_PARAM_REQ_BIT] = !pOk;
      stat2[ST2_ALWAYS_BIT] = 1'b1;
      stat2[ST2_SYNC_BIT] = sy;
      stat2[ST2_FREEZE_BIT] = fr;
   endfunction

   // Byte selection for the frame index.
   always_comb begin
      case (idx)
         IDX_STAT1: curByte = snapSt1;
         IDX_STAT2: curByte = snapSt2;
         IDX_STAT3: curByte = 8'h00;
         IDX_MASTER: curByte = masterReg;
         IDX_IDHI: curByte = IDENT_NUMBER[15:8];
         IDX_IDLO: curByte = IDENT_NUMBER[7:0];
         IDX_HDR: curByte = HDR_BYTE;
         IDX_DEVFLAG: curByte = {7'h00, snapDev};
         default: begin
            if (idx >= IDX_TAIL0 && idx <= IDX_LAST) begin
               curByte = TAIL_CONST[4'(idx - IDX_TAIL0)];
            end else begin
               curByte = 8'h00;
            end
         end
      endcase
   end

   // Bytes advance only while the FIFO accepts them, so a stalled sink
   // throttles the builder instead of losing bytes.
   assign pushByte = (state == SEND) && fifoInReady;
   assign snapTaken = (state == IDLE) && diagReq;
   assign diagBusy = (state == SEND);

   // Request acceptance and index sequencing.
   always_comb begin
      next_state = state;
      next_idx = idx;
      next_snapSt1 = snapSt1;
      next_snapSt2 = snapSt2;
      next_snapDev = snapDev;
      case (state)
         IDLE: begin
            if (diagReq) begin
               next_state = SEND;
               next_idx = IDX_STAT1;
               next_snapSt1 = stat1(eventPending);
               next_snapSt2 = stat2(paramOk, syncActive, freezeActive);
               next_snapDev = devDiagAvail;
            end
         end
         SEND: begin
            if (pushByte) begin
               if (idx == IDX_LAST) begin
                  next_state = IDLE;
               end else begin
                  next_idx = idx + 5'h01;
               end
            end
         end
         default: begin
            next_state = IDLE;
            next_idx = IDX_STAT1;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         state <= IDLE;
         idx <= IDX_STAT1;
         snapSt1 <= 8'h00;
         snapSt2 <= 8'h00;
         snapDev <= 1'b0;
      end else begin
         state <= next_state;
         idx <= next_idx;
         snapSt1 <= next_snapSt1;
         snapSt2 <= next_snapSt2;
         snapDev <= next_snapDev;
      end
   end

   // ----------------------------------------------------------------
   // Output buffer
   // ----------------------------------------------------------------
   frame_byte_t pushWord;
   logic [8:0] popWord;

   assign pushWord.data = curByte;
   assign pushWord.last = (idx == IDX_LAST);
   assign frameOut = frame_byte_t'(popWord);

   byte_fifo #(
      .WIDTH(9),
      .DEPTH(DEPTH)
   ) outFifo (
      .mclk(mclk),
      .rstN(rstN),
      .inValid(state == SEND),
      .inReady(fifoInReady),
      .inData(pushWord),
      .outValid(frameValid),
      .outReady(frameReady),
      .outData(popWord)
   );

endmodule

//--- shared/diag_framer_pkg.sv
package diag_framer_pkg;

   // ----------------------------------------------------------------
   // Group control command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_UNFREEZE = 8'h04;
   localparam logic [7:0] CMD_FREEZE = 8'h08;
   localparam logic [7:0] CMD_UNSYNC = 8'h10;
   localparam logic [7:0] CMD_SYNC = 8'h20;

   // ----------------------------------------------------------------
   // Diagnostic frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_LEN = 17;
   localparam logic [4:0] IDX_STAT1 = 5'h00;
   localparam logic [4:0] IDX_STAT2 = 5'h01;
   localparam logic [4:0] IDX_STAT3 = 5'h02;
   localparam logic [4:0] IDX_MASTER = 5'h03;
   localparam logic [4:0] IDX_IDHI = 5'h04;
   localparam logic [4:0] IDX_IDLO = 5'h05;
   localparam logic [4:0] IDX_HDR = 5'h06;
   localparam logic [4:0] IDX_DEVFLAG = 5'h07;
   localparam logic [4:0] IDX_LAST = 5'h10;
   localparam logic [7:0] HDR_BYTE = 8'h42;
   localparam int DEVFLAG_BIT = 0;
   // Fixed tail bytes 8..16, index 0 is byte 8.
   localparam logic [7:0] TAIL_CONST [0:8] = '{8'h05, 8'h82, 8'h00, 8'h00, 8'h00,
                                                8'h0f, 8'h81, 8'h01, 8'h00};
   localparam logic [4:0] IDX_TAIL0 = 5'h08;

   // Station status 1 cause bits and status 2 operating state bits.
   localparam int ST1_EXT_DIAG_BIT = 3;
   localparam int ST2_PARAM_REQ_BIT = 0;
   localparam int ST2_SYNC_BIT = 5;
   localparam int ST2_FREEZE_BIT = 4;
   localparam int ST2_ALWAYS_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values and depths
   // ----------------------------------------------------------------
   localparam logic [7:0] MASTER_ADDR_RST = 8'hff;
   localparam int FIFO_DEPTH = 8;

   // Command from the master side.
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] groups;
   } group_cmd_t;

   // Byte of the outgoing frame.
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } frame_byte_t;

endpackage

//--- verif/fieldbus_diag_monitor.sv
`timescale 1ns/100ps
module fieldbus_diag_monitor
   import diag_framer_pkg::*;
#(
   parameter logic [15:0] IDENT_NUMBER = 16'h1234,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] groupMember,
   input wire logic cmdValid,
   input wire group_cmd_t cmd,
   input wire logic [7:0] masterAddr,
   input wire logic masterAddrValid,
   input wire logic paramDone,
   input wire logic diagEvent,
   input wire logic devDiagAvail,
   input wire logic diagReq,
   input wire logic diagBusy,
   input wire logic frameValid,
   input wire logic frameReady,
   input wire frame_byte_t frameOut,
   input wire logic dxReq,
   input wire logic dxHighPrio,
   input wire logic syncActive,
   input wire logic freezeActive
);
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   logic evSeen;
   logic next_evSeen;
   logic hit;
   // Until the first event the priority has no reason to rise.
   assign hit = cmdValid && |(cmd.groups & groupMember);
   always_comb begin
      next_evSeen = evSeen | diagEvent;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         evSeen <= 1'b0;
      end else begin
         evSeen <= next_evSeen;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_sync_set: assert property (hit && cmd.code == CMD_SYNC |=> syncActive)
      else $error("sync not set");
   a_freeze_set: assert property (hit && cmd.code == CMD_FREEZE |=> freezeActive)
      else $error("freeze not set");
   a_unsync_clr: assert property (hit && cmd.code == CMD_UNSYNC |=> !syncActive)
      else $error("sync not cleared");
   a_unfreeze_clr: assert property (hit && cmd.code == CMD_UNFREEZE |=> !freezeActive)
      else $error("freeze not cleared");
   a_unaddr_hold: assert property (cmdValid && !hit |=> $stable({syncActive, freezeActive}))
      else $error("unaddressed command acted");
   a_req_busy: assert property (diagReq && !diagBusy |=> diagBusy)
      else $error("request not taken");
   a_stall_hold: assert property (frameValid && !frameReady |=> frameValid && $stable(frameOut))
      else $error("byte dropped under stall");
   a_prio_pend: assert property ((diagEvent && !diagBusy) ##1 !diagBusy ##1 (dxReq && !diagBusy)
      |=> dxHighPrio)
      else $error("priority not high");
   a_prio_low: assert property (dxReq && !evSeen && !diagEvent |=> !dxHighPrio)
      else $error("priority high without event");
   cover property (frameValid && frameReady && frameOut.last);
   cover property (dxReq ##1 dxHighPrio);
   cover property (syncActive && freezeActive);
   cover property (diagBusy && diagEvent);
endmodule

bind fieldbus_slave_diag_framer fieldbus_diag_monitor #(.IDENT_NUMBER(IDENT_NUMBER),
   .DEPTH(DEPTH)) i_mon (.mclk(mclk), .nrst(nrst), .groupMember(groupMember),
   .cmdValid(cmdValid), .cmd(cmd), .masterAddr(masterAddr), .masterAddrValid(masterAddrValid),
   .paramDone(paramDone), .diagEvent(diagEvent), .devDiagAvail(devDiagAvail),
   .diagReq(diagReq), .diagBusy(diagBusy), .frameValid(frameValid), .frameReady(frameReady),
   .frameOut(frameOut), .dxReq(dxReq), .dxHighPrio(dxHighPrio), .syncActive(syncActive),
   .freezeActive(freezeActive));

//--- verif/master_model.sv
`timescale 1ns/100ps
module master_model
   import diag_framer_pkg::*;
(
   input wire logic mclk,
   input wire logic stall,
   input wire logic frameValid,
   input wire frame_byte_t frameOut,
   output logic frameReady
);
   frame_byte_t got [0:255];
   int n = 0;
   logic [1:0] phase = 2'h0;
   // With stall set only one cycle in four accepts, so the FIFO fills and refuses.
   always @(negedge mclk) begin
      phase <= phase + 2'h1;
      frameReady <= !stall || phase == 2'h0;
   end
   // Every accepted byte is logged in arrival order.
   always @(posedge mclk) begin
      if (frameValid && frameReady) begin
         got[n % 256] <= frameOut;
         n <= n + 1;
      end
   end
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
   import diag_framer_pkg::*;
   localparam logic [15:0] ID = 16'h5a3c; // Arbitrary identification value.
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] groupMember = 8'h00;
   logic cmdValid = 1'b0;
   group_cmd_t cmd = '0;
   logic [7:0] masterAddr = 8'h00;
   logic masterAddrValid = 1'b0;
   logic paramDone = 1'b0;
   logic diagEvent = 1'b0;
   logic devDiagAvail = 1'b0;
   logic diagReq = 1'b0;
   logic dxReq = 1'b0;
   logic stall = 1'b0;
   logic diagBusy, frameValid, frameReady, dxHighPrio, syncActive, freezeActive;
   frame_byte_t frameOut;
   int failures = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h7165;
   logic sA = 1'b0, fA = 1'b0, pDone = 1'b0, pend = 1'b0;
   logic [7:0] addr = MASTER_ADDR_RST;
   logic [7:0] codes [0:4] = '{CMD_UNFREEZE, CMD_FREEZE, CMD_UNSYNC, CMD_SYNC, 8'h40};

   always #25 mclk = ~mclk;

   fieldbus_slave_diag_framer #(.IDENT_NUMBER(ID)) i_dut (.mclk(mclk), .nrst(nrst),
      .groupMember(groupMember), .cmdValid(cmdValid), .cmd(cmd), .masterAddr(masterAddr),
      .masterAddrValid(masterAddrValid), .paramDone(paramDone), .diagEvent(diagEvent),
      .devDiagAvail(devDiagAvail), .diagReq(diagReq), .diagBusy(diagBusy),
      .frameValid(frameValid), .frameReady(frameReady), .frameOut(frameOut), .dxReq(dxReq),
      .dxHighPrio(dxHighPrio), .syncActive(syncActive), .freezeActive(freezeActive));
   master_model i_master (.mclk(mclk), .stall(stall), .frameValid(frameValid),
      .frameOut(frameOut), .frameReady(frameReady));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected frame byte from the state the bench has been tracking.
   function automatic logic [7:0] expByte(int i, logic dev);
      case (i)
         0: return 8'(pend) << ST1_EXT_DIAG_BIT;
         1: return (8'(!pDone) << ST2_PARAM_REQ_BIT) | (8'h01 << ST2_ALWAYS_BIT) |
               (8'(fA) << ST2_FREEZE_BIT) | (8'(sA) << ST2_SYNC_BIT);
         2: return 8'h00;
         3: return addr;
         4: return ID[15:8];
         5: return ID[7:0];
         6: return HDR_BYTE;
         7: return 8'(dev) << DEVFLAG_BIT;
         default: return TAIL_CONST[i-8];
      endcase
   endfunction
   task summarize;
      $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chkByte(string what, logic [8:0] e, logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task chkBit(string what, logic e, logic g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", what, e, g);
      end
   endtask
   // Only known codes aimed at one of our groups move the expected levels.
   task sendCmd(logic [7:0] code, logic [7:0] grp);
      cmd = '{code, grp};
      cmdValid = 1'b1;
      @(negedge mclk);
      cmdValid = 1'b0;
      if (|(grp & groupMember)) begin
         if (code == CMD_SYNC) sA = 1'b1;
         if (code == CMD_UNSYNC) sA = 1'b0;
         if (code == CMD_FREEZE) fA = 1'b1;
         if (code == CMD_UNFREEZE) fA = 1'b0;
      end
      @(negedge mclk);
      chkBit("sync", sA, syncActive);
      chkBit("freeze", fA, freezeActive);
   endtask
   // A late event lands after the snapshot: absent from this frame, still pending after it.
   task frame(logic dev, logic late);
      int b;
      b = i_master.n;
      devDiagAvail = dev;
      diagReq = 1'b1;
      @(negedge mclk);
      diagReq = 1'b0;
      diagEvent = late;
      chkBit("busy", 1'b1, diagBusy);
      @(negedge mclk);
      diagEvent = 1'b0;
      for (int k = 0; k < 400 && i_master.n < b + 17; k++) @(negedge mclk);
      if (i_master.n < b + 17) begin
         failures++;
         $display("[ERR] frame expected 17 bytes seen %0d", i_master.n - b);
         summarize;
      end else begin
         for (int k = 0; k < 17; k++) begin
            chkByte("frame byte", {expByte(k, dev), k == 16}, i_master.got[(b + k) % 256]);
         end
         pend = late;
      end
   endtask
   task dx(logic e);
      dxReq = 1'b1;
      @(negedge mclk);
      dxReq = 1'b0;
      chkBit("priority", e, dxHighPrio);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      groupMember = 8'h05;
      sendCmd(CMD_SYNC, 8'h02);
      for (int i = 0; i < 5; i++) sendCmd(codes[i], 8'h04);
      sendCmd(CMD_SYNC, 8'h01);
      for (int i = 0; i < 24; i++) begin
         groupMember = 8'(rnd());
         sendCmd(codes[rnd() % 5], 8'(rnd()));
      end
      $display("group commands done");
      // The startup request runs against a stalling sink so the FIFO backs up.
      stall = 1'b1;
      frame(1'b0, 1'b0);
      dx(1'b0);
      $display("startup frame done");
      masterAddr = 8'(rnd());
      masterAddrValid = 1'b1;
      paramDone = 1'b1;
      @(negedge mclk);
      masterAddrValid = 1'b0;
      paramDone = 1'b0;
      addr = masterAddr;
      pDone = 1'b1;
      diagEvent = 1'b1;
      pend = 1'b1;
      @(negedge mclk);
      diagEvent = 1'b0;
      @(negedge mclk);
      dx(1'b1);
      dx(1'b1);
      stall = 1'b0;
      frame(1'b1, 1'b1);
      dx(1'b1);
      frame(1'b0, 1'b0);
      dx(1'b0);
      frame(1'b0, 1'b0);
      $display("event frame done");
      summarize;
   end
endmodule
